//--- verilog/pocc_pkg.sv
// Purpose: shared constants for the proximity offset calibration block
// Assumes: apb byte address is four times the register index
// Notes: indices below are kept as printed; some are not multiples of four
package pocc_pkg;
   // register indices (byte address = index * 4)
   localparam logic [9:0] IDX_OFFSET_MAG = 10'h0c0;
   localparam logic [9:0] IDX_OFFSET_SIGN = 10'h0c1;
   localparam logic [9:0] IDX_CALIB_CTRL = 10'h0d7;
   localparam logic [9:0] IDX_SPAN_EXT = 10'h0d8;
   localparam logic [9:0] IDX_CALIB_CFG = 10'h0d9;
   localparam logic [9:0] IDX_STATUS = 10'h0dc;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h0e0;
   localparam logic [9:0] IDX_PROX_RESULT = 10'h0e1;
   // address split
   localparam int ADDR_W = 12;
   localparam int IDX_LSB = 2;
   // field positions
   localparam int SPAN_EN_BIT = 5;
   localparam int SPAN_STEP_MSB = 4;
   localparam int GOAL_MSB = 7;
   localparam int GOAL_LSB = 5;
   localparam int ZDEC_BIT = 3;
   localparam int AVG_MSB = 2;
   localparam int CALIB_AVERAGING_ENABLE_BIT = 7;
   localparam int START_BIT = 0;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_DEC_BIT = 2;
   // reset values
   localparam logic [7:0] SPAN_EXT_RST = 8'h00;
   localparam logic [7:0] CALIB_CFG_RST = 8'h50;
   localparam logic [7:0] CALIB_CTRL_RST = 8'h00;
   localparam logic [7:0] STATUS_MASK = 8'h05;
   // data widths
   localparam int RES_W = 10;
   localparam int ACC_W = 14;
   localparam int SRCH_W = 9;
   localparam logic [SRCH_W-1:0] SRCH_BIAS = 9'h100;
   // largest averaging code (16 samples); above it is reserved
   localparam logic [2:0] AVG_CODE_MAX = 3'h4;
   // goal for each search goal code
   localparam logic [RES_W-1:0] GOAL_TABLE [8] = '{
      10'h003, 10'h007, 10'h00f, 10'h01f,
      10'h03f, 10'h07f, 10'h0ff, 10'h1ff};
endpackage : pocc_pkg

//--- verilog/pocc_averager.sv
// Purpose: gathers converter samples and averages them by shifting
// Assumes: sample_valid answers each sample_start, same clock
// Notes: count is a power of two so the divide is a shift
module pocc_averager (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic start,
   input wire logic [2:0] avg_log2,
   output logic busy,
   // converter side
   output logic sample_start,
   input wire logic sample_valid,
   input wire logic [pocc_pkg::RES_W-1:0] sample_data,
   // result
   output logic done,
   output logic [pocc_pkg::RES_W-1:0] average
);
   logic [pocc_pkg::ACC_W-1:0] acc;
   logic [4:0] left;
   logic [2:0] shift;
   logic waiting;
   wire logic [pocc_pkg::ACC_W-1:0] next_acc =
      acc + {{(pocc_pkg::ACC_W-pocc_pkg::RES_W){1'b0}}, sample_data};
   wire logic last = (left == 5'h01);
   wire logic [pocc_pkg::ACC_W-1:0] shifted = next_acc >> shift;

   assign busy = waiting;

   // each sample is its own full burst request; sum until count is reached
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc <= '0;
         left <= 5'h00;
         shift <= 3'h0;
         waiting <= 1'b0;
         sample_start <= 1'b0;
         done <= 1'b0;
         average <= '0;
      end else begin
         sample_start <= 1'b0;
         done <= 1'b0;
         if (start && !waiting) begin
            acc <= '0;
            left <= 5'(5'h01 << avg_log2);
            shift <= avg_log2;
            waiting <= 1'b1;
            sample_start <= 1'b1;
         end else if (waiting && sample_valid) begin
            acc <= next_acc;
            left <= left - 5'h01;
            if (last) begin
               waiting <= 1'b0;
               done <= 1'b1;
               average <= shifted[pocc_pkg::RES_W-1:0];
            end else begin
               sample_start <= 1'b1;
            end
         end
      end
   end
endmodule : pocc_averager

//--- verilog/pocc_calib_search.sv
// Purpose: binary search of the signed offset toward a goal result
// Assumes: a larger offset code gives a larger proximity result
// Notes: code is biased by 256; code 0 is clamped to -255
module pocc_calib_search (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic start,
   input wire logic [pocc_pkg::RES_W-1:0] goal,
   output logic busy,
   output logic done,
   // measurement handshake
   output logic meas_req,
   input wire logic meas_done,
   input wire logic [pocc_pkg::RES_W-1:0] meas_value,
   // trial offset as magnitude and sign
   output logic [7:0] trial_mag,
   output logic trial_sign
);
   typedef enum logic [1:0] {S_IDLE, S_TRY, S_WAIT} pocc_srch_e;
   pocc_srch_e state;
   logic [pocc_pkg::SRCH_W-1:0] code;
   logic [3:0] bit_ix;
   wire logic [pocc_pkg::SRCH_W-1:0] one_hot =
      pocc_pkg::SRCH_W'(1) << bit_ix;
   wire logic over = meas_value > goal;
   wire logic neg = code < pocc_pkg::SRCH_BIAS;
   wire logic [pocc_pkg::SRCH_W-1:0] neg_mag = pocc_pkg::SRCH_BIAS - code;
   wire logic [pocc_pkg::SRCH_W-1:0] pos_mag = code - pocc_pkg::SRCH_BIAS;

   // sign/magnitude view of the biased code, limited to 255
   assign busy = (state != S_IDLE);
   assign trial_sign = neg;
   assign trial_mag = !neg ? pos_mag[7:0] :
                      (neg_mag[8] ? 8'hff : neg_mag[7:0]);

   // one bit per step, most significant first
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= S_IDLE;
         code <= '0;
         bit_ix <= 4'h0;
         meas_req <= 1'b0;
         done <= 1'b0;
      end else begin
         meas_req <= 1'b0;
         done <= 1'b0;
         unique case (state)
            S_IDLE: begin
               if (start) begin
                  code <= '0;
                  bit_ix <= 4'(pocc_pkg::SRCH_W - 1);
                  state <= S_TRY;
               end
            end
            S_TRY: begin
               code <= code | one_hot;
               meas_req <= 1'b1;
               state <= S_WAIT;
            end
            S_WAIT: begin
               if (meas_done) begin
                  // keep the bit only while result stays at or under goal
                  if (over) begin
                     code <= code & ~one_hot;
                  end
                  if (bit_ix == 4'h0) begin
                     state <= S_IDLE;
                     done <= 1'b1;
                  end else begin
                     bit_ix <= bit_ix - 4'h1;
                     state <= S_TRY;
                  end
               end
            end
         endcase
      end
   end
endmodule : pocc_calib_search

//--- verilog/pocc_top.sv
// Purpose: proximity offset calibration, averaging and auto decrement
// Assumes: apb master on clk; converter logic on the same clock
// Notes: registers sit at byte address four times their index
//
// Added by the designer: the APB slave port.
module pocc_top (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pocc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // proximity engine side
   input wire logic prox_cycle_start,
   output logic sample_start,
   input wire logic sample_valid,
   input wire logic [pocc_pkg::RES_W-1:0] sample_data,
   output logic result_write,
   // offset and range to the front end
   output logic [7:0] offset_magnitude_out,
   output logic offset_sign_out,
   output logic range_ext_active,
   output logic [4:0] range_ext_steps,
   // interrupt
   output logic irq
);
   // register state
   logic [7:0] span_ext;
   logic [7:0] calib_cfg;
   logic [7:0] calib_ctrl;
   logic [7:0] offset_magnitude;
   logic offset_sign;
   logic [7:0] irq_mask;
   logic calib_done_flag;
   logic offset_decremented_flag;
   logic [pocc_pkg::RES_W-1:0] proximity_result;
   logic rdy;
   logic err;

   // apb decode: one wait state, writes act at the pready edge
   wire logic [9:0] idx = paddr[pocc_pkg::ADDR_W-1:pocc_pkg::IDX_LSB];
   wire logic aligned = (paddr[pocc_pkg::IDX_LSB-1:0] == 2'h0);
   wire logic hit_mag = aligned && (idx == pocc_pkg::IDX_OFFSET_MAG);
   wire logic hit_sign = aligned && (idx == pocc_pkg::IDX_OFFSET_SIGN);
   wire logic hit_ctrl = aligned && (idx == pocc_pkg::IDX_CALIB_CTRL);
   wire logic hit_span = aligned && (idx == pocc_pkg::IDX_SPAN_EXT);
   wire logic hit_cfg = aligned && (idx == pocc_pkg::IDX_CALIB_CFG);
   wire logic hit_stat = aligned && (idx == pocc_pkg::IDX_STATUS);
   wire logic hit_mask = aligned && (idx == pocc_pkg::IDX_IRQ_MASK);
   wire logic hit_res = aligned && (idx == pocc_pkg::IDX_PROX_RESULT);
   wire logic hit_any = hit_mag | hit_sign | hit_ctrl | hit_span |
                        hit_cfg | hit_stat | hit_mask | hit_res;
   wire logic access = psel && penable && !rdy;
   wire logic wr = psel && penable && rdy && pwrite && !err;
   wire logic [7:0] wbyte = pwdata[7:0];

   // configuration fields
   wire logic [2:0] goal_code =
      calib_cfg[pocc_pkg::GOAL_MSB:pocc_pkg::GOAL_LSB];
   wire logic [2:0] avg_code = calib_cfg[pocc_pkg::AVG_MSB:0];
   wire logic zdec_en = calib_cfg[pocc_pkg::ZDEC_BIT];
   wire logic calib_averaging_enable = calib_ctrl[pocc_pkg::CALIB_AVERAGING_ENABLE_BIT];
   wire logic [pocc_pkg::RES_W-1:0] goal =
      pocc_pkg::GOAL_TABLE[goal_code];

   // calibration and averaging wiring
   logic srch_busy;
   logic srch_done;
   logic srch_req;
   logic [7:0] trial_mag;
   logic trial_sign;
   logic avg_busy;
   logic avg_done;
   logic [pocc_pkg::RES_W-1:0] avg_value;
   logic pend_normal;

   // reserved averaging codes fall back to a single sample
   wire logic avg_code_ok = (avg_code <= pocc_pkg::AVG_CODE_MAX);
   wire logic [2:0] norm_log2 = avg_code_ok ? avg_code : 3'h0;
   wire logic [2:0] cal_log2 = calib_averaging_enable ? norm_log2 : 3'h0;
   wire logic [2:0] use_log2 = srch_busy ? cal_log2 : norm_log2;

   // a normal cycle waits while calibration owns the converter
   wire logic start_normal = pend_normal && !srch_busy && !avg_busy;
   wire logic avg_start = srch_req || start_normal;
   wire logic cal_start = wr && hit_ctrl && wbyte[pocc_pkg::START_BIT] &&
                          !srch_busy;

   // zero result outside calibration triggers a decrement
   wire logic zero_event = avg_done && !srch_busy && zdec_en &&
                           (avg_value == '0);
   wire logic can_dec = (offset_magnitude != 8'h00);

   // flag clears: write one to status, or decrement disable
   wire logic clr_done = wr && hit_stat && wbyte[pocc_pkg::ST_DONE_BIT];
   wire logic clr_dec = (wr && hit_stat && wbyte[pocc_pkg::ST_DEC_BIT]) ||
                        !zdec_en;

   // status word and read mux
   wire logic [7:0] status_word = {5'h00, offset_decremented_flag, 1'b0,
                                   calib_done_flag};
   wire logic [7:0] ctrl_word = {calib_ctrl[7:1], srch_busy};
   wire logic [31:0] rd_word =
      hit_mag ? {24'h0, offset_magnitude} :
      hit_sign ? {31'h0, offset_sign} :
      hit_ctrl ? {24'h0, ctrl_word} :
      hit_span ? {24'h0, span_ext} :
      hit_cfg ? {24'h0, calib_cfg} :
      hit_stat ? {24'h0, status_word} :
      hit_mask ? {24'h0, irq_mask} :
      hit_res ? {22'h0, proximity_result} : 32'h0;

   pocc_calib_search u_search (
      .clk(clk),
      .resetn(resetn),
      .start(cal_start),
      .goal(goal),
      .busy(srch_busy),
      .done(srch_done),
      .meas_req(srch_req),
      .meas_done(avg_done),
      .meas_value(avg_value),
      .trial_mag(trial_mag),
      .trial_sign(trial_sign)
   );

   pocc_averager u_avg (
      .clk(clk),
      .resetn(resetn),
      .start(avg_start),
      .avg_log2(use_log2),
      .busy(avg_busy),
      .sample_start(sample_start),
      .sample_valid(sample_valid),
      .sample_data(sample_data),
      .done(avg_done),
      .average(avg_value)
   );

   // front end sees the trial offset while the search runs
   assign offset_magnitude_out = srch_busy ? trial_mag : offset_magnitude;
   assign offset_sign_out = srch_busy ? trial_sign : offset_sign;
   assign range_ext_active = span_ext[pocc_pkg::SPAN_EN_BIT];
   assign range_ext_steps = range_ext_active ?
      span_ext[pocc_pkg::SPAN_STEP_MSB:0] : 5'h00;
   assign irq = |(status_word & irq_mask & pocc_pkg::STATUS_MASK);
   assign pready = rdy;
   assign pslverr = err;

   // apb answer: pready one cycle into the access phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdy <= 1'b0;
         err <= 1'b0;
         prdata <= 32'h0;
      end else begin
         rdy <= access;
         err <= access && !hit_any;
         if (access && !pwrite) begin
            prdata <= rd_word;
         end
      end
   end

   // span and config registers keep every bit the host writes; irq_mask keeps only bits 0 and 2
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         span_ext <= pocc_pkg::SPAN_EXT_RST;
         calib_cfg <= pocc_pkg::CALIB_CFG_RST;
         irq_mask <= 8'h00;
      end else begin
         if (wr && hit_span) begin
            span_ext <= wbyte;
         end
         if (wr && hit_cfg) begin
            calib_cfg <= wbyte;
         end
         if (wr && hit_mask) begin
            irq_mask <= wbyte & pocc_pkg::STATUS_MASK;
         end
      end
   end

   // start bit is a trigger and is not stored
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         calib_ctrl <= pocc_pkg::CALIB_CTRL_RST;
      end else if (wr && hit_ctrl) begin
         calib_ctrl <= {wbyte[7:1], 1'b0};
      end
   end

   // offset: search result wins over a host write in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         offset_magnitude <= 8'h00;
         offset_sign <= 1'b0;
      end else if (srch_done) begin
         offset_magnitude <= trial_mag;
         offset_sign <= trial_sign;
      end else if (zero_event && can_dec) begin
         offset_magnitude <= offset_magnitude - 8'h01;
      end else begin
         if (wr && hit_mag) begin
            offset_magnitude <= wbyte;
         end
         if (wr && hit_sign) begin
            offset_sign <= wbyte[0];
         end
      end
   end

   // result is written only from a finished average
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         proximity_result <= '0;
         result_write <= 1'b0;
      end else begin
         result_write <= avg_done;
         if (avg_done) begin
            proximity_result <= avg_value;
         end
      end
   end

   // a cycle request arriving mid-calibration is held, not dropped
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pend_normal <= 1'b0;
      end else if (prox_cycle_start) begin
         pend_normal <= 1'b1;
      end else if (start_normal) begin
         pend_normal <= 1'b0;
      end
   end

   // sticky flags: a set in the clearing cycle survives
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         calib_done_flag <= 1'b0;
         offset_decremented_flag <= 1'b0;
      end else begin
         if (srch_done) begin
            calib_done_flag <= 1'b1;
         end else if (clr_done) begin
            calib_done_flag <= 1'b0;
         end
         if (zero_event && can_dec) begin
            offset_decremented_flag <= 1'b1;
         end else if (clr_dec) begin
            offset_decremented_flag <= 1'b0;
         end
      end
   end
endmodule : pocc_top

//--- dv/pocc_chk.sv
// Purpose: port checks for the offset calibration block
// Assumes: one clock, async active-low reset
// Notes: apb answers in the second access cycle
module pocc_chk (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // engine side
   input wire logic sample_start,
   input wire logic sample_valid,
   input wire logic result_write,
   input wire logic range_ext_active,
   input wire logic [4:0] range_ext_steps,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic pend;
   // a sample is outstanding from request until the converter answers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pend <= 1'b0;
      end else if (sample_start) begin
         pend <= 1'b1;
      end else if (sample_valid) begin
         pend <= 1'b0;
      end
   end
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("apb access not answered");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   err_pair_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_rdzero_a: assert property (pready && pslverr && !pwrite |->
      prdata == 32'h0) else $error("refused read returns data");
   range_gate_a: assert property (!range_ext_active |->
      range_ext_steps == 5'h00) else $error("steps while inactive");
   sample_pulse_a: assert property (sample_start |=> !sample_start)
      else $error("sample request longer than a pulse");
   sample_one_a: assert property (sample_start |-> !pend)
      else $error("second sample requested early");
   result_order_a: assert property (result_write |-> $past(sample_valid)
      || $past(sample_valid, 2) || $past(sample_valid, 3))
      else $error("result written without a finished sample");
   cover property (result_write);
   cover property (range_ext_active);
   cover property (irq);
   cover property (pready && pslverr);
endmodule : pocc_chk

bind pocc_top pocc_chk u_pocc_chk (.clk(clk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sample_start(sample_start),
   .sample_valid(sample_valid), .result_write(result_write),
   .range_ext_active(range_ext_active), .range_ext_steps(range_ext_steps),
   .irq(irq));

//--- dv/test_prox_offset_calib_config.sv
// Purpose: self-checking bench for the offset calibration block
// Assumes: converter modelled inline, result follows signed offset
// Notes: converter adds 3 on every other sample when alt is set
module test_prox_offset_calib_config;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, prox_cycle_start = 1'b0, sample_valid = 1'b0;
   logic [pocc_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [pocc_pkg::RES_W-1:0] sample_data = '0;
   logic pready, pslverr, sample_start, result_write, irq, err;
   logic offset_sign_out, range_ext_active, tog = 1'b0, alt = 1'b0;
   logic [7:0] offset_magnitude_out;
   logic [4:0] range_ext_steps;
   int error_cnt = 0, checked = 0, nsamp = 0, base = 0;

   pocc_top DUT (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prox_cycle_start(prox_cycle_start), .sample_start(sample_start),
      .sample_valid(sample_valid), .sample_data(sample_data),
      .result_write(result_write),
      .offset_magnitude_out(offset_magnitude_out),
      .offset_sign_out(offset_sign_out),
      .range_ext_active(range_ext_active),
      .range_ext_steps(range_ext_steps), .irq(irq));

   initial begin
      forever #25 clk = ~clk;
   end

   // converter answers a request next cycle; data scrambles when idle
   always @(posedge clk) begin : conv
      int v;
      sample_valid <= 1'b0;
      sample_data <= ~sample_data;
      if (sample_start === 1'b1) begin
         v = base + ((alt && tog) ? 3 : 0);
         v = offset_sign_out ? v - offset_magnitude_out
            : v + offset_magnitude_out;
         v = v < 0 ? 0 : (v > 1023 ? 1023 : v);
         sample_data <= v[9:0];
         sample_valid <= 1'b1;
         tog <= ~tog;
         nsamp++;
      end
   end

   task automatic results();
      if (error_cnt == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [9:0] idx,
         input logic [7:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // pready and prdata are read as they stood before this edge
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the edge's register updates settle before callers look
      @(negedge clk);
   endtask : apb

   task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask : rdchk

   // one measurement, waits for the result write
   task automatic meas();
      int n;
      tog = 1'b0;
      nsamp = 0;
      @(posedge clk);
      prox_cycle_start <= 1'b1;
      @(posedge clk);
      prox_cycle_start <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (result_write !== 1'b1 && n < 500);
      if (n >= 500) error_cnt++;
      repeat (2) @(posedge clk);
   endtask : meas

   task automatic t_reset();
      rdchk(pocc_pkg::IDX_SPAN_EXT, 32'h00);
      rdchk(pocc_pkg::IDX_CALIB_CFG, 32'h50);
      apb(1'b1, 10'h3aa, 8'hff);
      chk({31'h0, err}, 32'h1);
      rdchk(10'h3aa, 32'h0);
      chk({30'h0, irq, range_ext_active}, 32'h0);
   endtask : t_reset

   task automatic t_range();
      logic [7:0] tbl [5] = '{8'h20, 8'h3f, 8'h1f, 8'h25, 8'h00};
      foreach (tbl[i]) begin
         apb(1'b1, pocc_pkg::IDX_SPAN_EXT, tbl[i]);
         chk({31'h0, range_ext_active}, {31'h0, tbl[i][5]});
         chk({27'h0, range_ext_steps},
            {27'h0, tbl[i][5] ? tbl[i][4:0] : 5'h00});
         rdchk(pocc_pkg::IDX_SPAN_EXT, {24'h0, tbl[i]});
      end
   endtask : t_range

   // codes 1..4 average alternating samples, so truncation shows
   task automatic t_avg();
      base = 40;
      alt = 1'b1;
      for (int c = 0; c < 6; c++) begin
         apb(1'b1, pocc_pkg::IDX_CALIB_CFG, {5'h0a, c[2:0]});
         meas();
         chk(nsamp, c > 4 ? 1 : 1 << c);
         rdchk(pocc_pkg::IDX_PROX_RESULT, (c > 0 && c < 5) ? 41 : 40);
      end
   endtask : t_avg

   task automatic t_dec();
      base = 0;
      alt = 1'b0;
      apb(1'b1, pocc_pkg::IDX_OFFSET_MAG, 8'h02);
      apb(1'b1, pocc_pkg::IDX_OFFSET_SIGN, 8'h01);
      apb(1'b1, pocc_pkg::IDX_CALIB_CFG, 8'h58);
      meas();
      rdchk(pocc_pkg::IDX_OFFSET_MAG, 32'h1);
      rdchk(pocc_pkg::IDX_STATUS, 32'h4);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, pocc_pkg::IDX_IRQ_MASK, 8'h04);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, pocc_pkg::IDX_STATUS, 8'h04);
      chk({31'h0, irq}, 32'h0);
      meas();
      rdchk(pocc_pkg::IDX_OFFSET_MAG, 32'h0);
      apb(1'b1, pocc_pkg::IDX_CALIB_CFG, 8'h50);
      rdchk(pocc_pkg::IDX_STATUS, 32'h0);
      apb(1'b1, pocc_pkg::IDX_CALIB_CFG, 8'h58);
      meas();
      rdchk(pocc_pkg::IDX_OFFSET_MAG, 32'h0);
      rdchk(pocc_pkg::IDX_STATUS, 32'h0);
      apb(1'b1, pocc_pkg::IDX_IRQ_MASK, 8'h01);
   endtask : t_dec

   // every goal code; odd codes also average during the search
   task automatic t_cal();
      int n, off, best;
      base = 100;
      for (int g = 0; g < 8; g++) begin
         best = -255;
         for (int c = 1; c < 512; c++) begin
            off = c - 256;
            if ((base + off < 0 ? 0 : base + off) <= (4 << g) - 1) best = off;
         end
         apb(1'b1, pocc_pkg::IDX_CALIB_CFG, {g[2:0], 5'h11});
         nsamp = 0;
         apb(1'b1, pocc_pkg::IDX_CALIB_CTRL, {g[0], 7'h01});
         n = 0;
         do begin
            apb(1'b0, pocc_pkg::IDX_STATUS, 8'h00);
            n++;
         end while (rd[0] !== 1'b1 && n < 100);
         chk({31'h0, irq}, 32'h1);
         chk(nsamp, g[0] ? 18 : 9);
         rdchk(pocc_pkg::IDX_OFFSET_MAG, best < 0 ? -best : best);
         rdchk(pocc_pkg::IDX_OFFSET_SIGN, best < 0 ? 1 : 0);
         chk({24'h0, offset_magnitude_out}, best < 0 ? -best : best);
         chk({31'h0, offset_sign_out}, best < 0 ? 1 : 0);
         apb(1'b1, pocc_pkg::IDX_STATUS, 8'h01);
      end
   endtask : t_cal

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_range();
      t_avg();
      t_dec();
      t_cal();
      results();
   end

   // watchdog well beyond the expected thousand or so cycles
   initial begin
      repeat (50000) @(posedge clk);
      error_cnt++;
      results();
   end
endmodule : test_prox_offset_calib_config
